// File: rtl/csbu_pkg.sv
// Purpose: Shared types and constants for the compare, skip and branch unit
// Assumes: 8-bit data, program counter width set by the top-level parameter
// Notes:   Status register bit order is C Z N V S H T I from bit 0 upward
package csbu_pkg;

    // ==========================================================
    // Status register bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;

    // ==========================================================
    // Reset values and increments
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [1:0] SKIP_INC_ONE  = 2'h2;
    localparam logic [1:0] SKIP_INC_TWO  = 2'h3;
    localparam logic [1:0] SKIP_EXTRA_ONE = 2'h1;
    localparam logic [1:0] SKIP_EXTRA_TWO = 2'h2;

    // ==========================================================
    // Operations handled by the unit
    typedef enum logic [3:0] {
        CSBU_OP_NONE,
        CSBU_OP_COMPARE_IMMEDIATE,
        CSBU_OP_SKIP_REG_BIT_CLEAR,
        CSBU_OP_SKIP_IO_BIT_SET,
        CSBU_OP_BRANCH_FLAG_SET,
        CSBU_OP_BRANCH_FLAG_CLEAR,
        CSBU_OP_BRANCH_CARRY_CLEAR,
        CSBU_OP_BRANCH_SIGNED_GE,
        CSBU_OP_BRANCH_SIGNED_LT
    } csbu_op_e;

    // Decoded instruction from the decoder
    typedef struct packed {
        csbu_op_e    op;
        logic [7:0]  reg_val;
        logic [7:0]  imm_val;
        logic [7:0]  io_val;
        logic [2:0]  bit_sel;
        logic [6:0]  offset;
        logic        next_two_words;
    } csbu_instr_s;

    // Execution sequencer states
    typedef enum logic [1:0] {
        CSBU_ST_IDLE,
        CSBU_ST_WAIT
    } csbu_state_e;

endpackage

// File: rtl/csbu_cond.sv
// Purpose: Combinational condition evaluation and compare flag computation
// Assumes: Operands valid while the instruction is presented
// Notes:   Leaves flags it does not own unchanged
`timescale 1ns/1ps
module csbu_cond
    import csbu_pkg::*;
(
    // Instruction and flags
    input  wire csbu_instr_s instr_i,
    input  wire logic [7:0]  status_i,
    // Results
    output logic             taken_o,
    output logic             is_skip_o,
    output logic             is_branch_o,
    output logic [7:0]       cmp_status_o
);
    logic [8:0] diff;
    logic       n_x;
    logic       v_x;
    logic       h_x;
    logic       z_x;

    always_comb begin
        diff = {1'b0, instr_i.reg_val} - {1'b0, instr_i.imm_val};
        n_x  = diff[7];
        z_x  = (diff[7:0] == 8'h00);
        v_x  = (instr_i.reg_val[7] & ~instr_i.imm_val[7] & ~diff[7])
             | (~instr_i.reg_val[7] & instr_i.imm_val[7] & diff[7]);
        h_x  = (~instr_i.reg_val[3] & instr_i.imm_val[3])
             | (instr_i.imm_val[3] & diff[3])
             | (diff[3] & ~instr_i.reg_val[3]);
        cmp_status_o          = status_i;
        cmp_status_o[FLAG_C]  = diff[8];
        cmp_status_o[FLAG_Z]  = z_x;
        cmp_status_o[FLAG_N]  = n_x;
        cmp_status_o[FLAG_V]  = v_x;
        cmp_status_o[FLAG_S]  = n_x ^ v_x;
        cmp_status_o[FLAG_H]  = h_x;
        taken_o     = 1'b0;
        is_skip_o   = 1'b0;
        is_branch_o = 1'b0;
        unique case (instr_i.op)
            CSBU_OP_SKIP_REG_BIT_CLEAR: begin
                is_skip_o = 1'b1;
                taken_o   = ~instr_i.reg_val[instr_i.bit_sel];
            end
            CSBU_OP_SKIP_IO_BIT_SET: begin
                is_skip_o = 1'b1;
                taken_o   = instr_i.io_val[instr_i.bit_sel];
            end
            CSBU_OP_BRANCH_FLAG_SET: begin
                is_branch_o = 1'b1;
                taken_o     = status_i[instr_i.bit_sel];
            end
            CSBU_OP_BRANCH_FLAG_CLEAR: begin
                is_branch_o = 1'b1;
                taken_o     = ~status_i[instr_i.bit_sel];
            end
            CSBU_OP_BRANCH_CARRY_CLEAR: begin
                is_branch_o = 1'b1;
                taken_o     = ~status_i[FLAG_C];
            end
            CSBU_OP_BRANCH_SIGNED_GE: begin
                is_branch_o = 1'b1;
                taken_o     = ~(status_i[FLAG_N] ^ status_i[FLAG_V]);
            end
            CSBU_OP_BRANCH_SIGNED_LT: begin
                is_branch_o = 1'b1;
                taken_o     = status_i[FLAG_N] ^ status_i[FLAG_V];
            end
            CSBU_OP_COMPARE_IMMEDIATE,
            CSBU_OP_NONE: begin
                taken_o = 1'b0;
            end
            default: begin
                taken_o = 1'b0;
            end
        endcase
    end

endmodule

// File: rtl/csbu_top.sv
// Purpose: Compare, skip and conditional branch execution for an 8-bit core
// Assumes: Decoder holds the instruction stable until done_o
// Notes:   Program counter counts in words
// Notes on behaviour
// - Compare immediate subtracts constant, sets Z N V C H S, stores nothing.
// - Skip when register bit clear; PC plus two or three; flags kept.
// - Skip when I/O register bit set; PC plus two or three.
// - Branch when selected status bit set; PC plus offset plus one.
// - Branch when selected status bit clear; otherwise continue; flags kept.
// - Branch when carry clear; fall through when carry set.
// - Signed greater-or-equal branch taken when first operand not smaller.
// - Signed less-than branch taken when first operand smaller.
`timescale 1ns/1ps
module csbu_top
    import csbu_pkg::*;
#(
    parameter int unsigned PC_W = 12
) (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Instruction from decoder
    input  wire logic              start_i,
    input  wire csbu_instr_s       instr_i,
    input  wire logic [PC_W-1:0]   pc_i,
    // Status register
    input  wire logic [7:0]        status_i,
    output logic [7:0]             status_o,
    output logic                   status_we_o,
    // Program counter update
    output logic [PC_W-1:0]        pc_o,
    output logic                   pc_we_o,
    output logic                   done_o,
    output logic                   busy_o
);
    typedef struct packed {
        csbu_state_e     state;
        logic [1:0]      wait_cnt;
        logic [PC_W-1:0] pc;
        logic            pc_we;
        logic [7:0]      status;
        logic            status_we;
        logic            done;
    } csbu_regs_s;

    csbu_regs_s r_q;
    csbu_regs_s r_d;
    logic       taken;
    logic       is_skip;
    logic       is_branch;
    logic [7:0] cmp_status;
    logic [PC_W-1:0] off_ext;
    logic [PC_W-1:0] skip_inc;

    // ==========================================================
    // Condition evaluation
    csbu_cond u_cond (
        .instr_i      (instr_i),
        .status_i     (status_i),
        .taken_o      (taken),
        .is_skip_o    (is_skip),
        .is_branch_o  (is_branch),
        .cmp_status_o (cmp_status)
    );

    assign off_ext  = PC_W'(signed'(instr_i.offset));
    assign skip_inc = PC_W'(instr_i.next_two_words ? SKIP_INC_TWO : SKIP_INC_ONE);

    // ==========================================================
    // Sequencer: one cycle, extra cycles when a skip or branch is taken
    always_comb begin
        r_d           = r_q;
        r_d.pc_we     = 1'b0;
        r_d.status_we = 1'b0;
        r_d.done      = 1'b0;
        unique case (r_q.state)
            CSBU_ST_IDLE: begin
                if (start_i && instr_i.op != CSBU_OP_NONE) begin
                    if (instr_i.op == CSBU_OP_COMPARE_IMMEDIATE) begin
                        r_d.status    = cmp_status;
                        r_d.status_we = 1'b1;
                        r_d.done      = 1'b1;
                    end else if (taken && is_skip) begin
                        r_d.pc       = pc_i + skip_inc;
                        r_d.wait_cnt = instr_i.next_two_words ? SKIP_EXTRA_TWO
                                                              : SKIP_EXTRA_ONE;
                        r_d.state    = CSBU_ST_WAIT;
                    end else if (taken && is_branch) begin
                        r_d.pc       = pc_i + off_ext + PC_W'(1);
                        r_d.wait_cnt = SKIP_EXTRA_ONE;
                        r_d.state    = CSBU_ST_WAIT;
                    end else begin
                        // Not taken: fall through in one cycle, flags untouched
                        r_d.pc    = pc_i + PC_W'(1);
                        r_d.pc_we = 1'b1;
                        r_d.done  = 1'b1;
                    end
                end
            end
            CSBU_ST_WAIT: begin
                r_d.wait_cnt = r_q.wait_cnt - 2'h1;
                if (r_q.wait_cnt == 2'h1) begin
                    r_d.pc_we = 1'b1;
                    r_d.done  = 1'b1;
                    r_d.state = CSBU_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            r_q.state     <= CSBU_ST_IDLE;
            r_q.wait_cnt  <= 2'h0;
            r_q.pc        <= '0;
            r_q.pc_we     <= 1'b0;
            r_q.status    <= STATUS_RESET;
            r_q.status_we <= 1'b0;
            r_q.done      <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // Outputs
    assign status_o    = r_q.status;
    assign status_we_o = r_q.status_we;
    assign pc_o        = r_q.pc;
    assign pc_we_o     = r_q.pc_we;
    assign done_o      = r_q.done;
    assign busy_o      = (r_q.state != CSBU_ST_IDLE);

endmodule

// File: tb/csbu_fetch_model.sv
// Purpose: Fetch side model holding the program counter
// Assumes: New value taken on the update pulse
// Notes:   Start address is arbitrary
`timescale 1ns/1ps
module csbu_fetch_model #(
    parameter int unsigned PC_W = 12
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Update from the unit
    input  wire logic            pc_we_i,
    input  wire logic [PC_W-1:0] pc_new_i,
    output logic      [PC_W-1:0] pc_o
);
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_o <= PC_W'(12'h100);
        end else if (pc_we_i) begin
            pc_o <= pc_new_i;
        end
    end
endmodule

// File: tb/csbu_top_assertions.sv
// Purpose: Timing and result checks at the unit ports
// Assumes: Single clock, reset asynchronous active high
// Notes:   Attached by bind
`timescale 1ns/1ps
module csbu_top_assertions
    import csbu_pkg::*;
#(
    parameter int unsigned PC_W = 12
) (
    input wire logic            clk_sys_i,
    input wire logic            rst_i,
    input wire logic            start_i,
    input wire csbu_instr_s     instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0]      status_i,
    input wire logic [7:0]      status_o,
    input wire logic            status_we_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic            pc_we_o,
    input wire logic            done_o,
    input wire logic            busy_o
);
    logic            go;
    logic [PC_W-1:0] tgt;
    csbu_op_e        op;
    assign go = start_i && !busy_o;
    assign op = instr_i.op;
    assign tgt = pc_i + {{(PC_W-7){instr_i.offset[6]}}, instr_i.offset} + 1'b1;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Checks
    a_cmp_done: assert property (
        go && op == CSBU_OP_COMPARE_IMMEDIATE |=> status_we_o && done_o && !pc_we_o)
        else $error("compare timing wrong");
    a_cmp_zero: assert property (
        go && op == CSBU_OP_COMPARE_IMMEDIATE |=>
        status_o[FLAG_Z] == ($past(instr_i.reg_val) == $past(instr_i.imm_val)))
        else $error("compare zero flag wrong");
    a_cmp_carry: assert property (
        go && op == CSBU_OP_COMPARE_IMMEDIATE |=>
        status_o[FLAG_C] == ($past(instr_i.reg_val) < $past(instr_i.imm_val)))
        else $error("compare carry flag wrong");
    a_skip_reg: assert property (
        go && op == CSBU_OP_SKIP_REG_BIT_CLEAR && !instr_i.reg_val[instr_i.bit_sel]
        && !instr_i.next_two_words |=> busy_o ##1 pc_we_o && pc_o == PC_W'($past(pc_i, 2) + 2))
        else $error("register skip wrong");
    a_skip_io: assert property (
        go && op == CSBU_OP_SKIP_IO_BIT_SET && instr_i.io_val[instr_i.bit_sel]
        && instr_i.next_two_words |=> busy_o [*2] ##1 pc_we_o && pc_o == PC_W'($past(pc_i, 3) + 3))
        else $error("io skip wrong");
    a_flag_set: assert property (
        go && op == CSBU_OP_BRANCH_FLAG_SET && status_i[instr_i.bit_sel]
        |=> busy_o ##1 done_o && pc_o == $past(tgt, 2))
        else $error("flag set branch wrong");
    a_clear_fall: assert property (
        go && op == CSBU_OP_BRANCH_FLAG_CLEAR && status_i[instr_i.bit_sel]
        |=> pc_we_o && pc_o == PC_W'($past(pc_i) + 1))
        else $error("flag clear fall through wrong");
    a_carry_clear: assert property (
        go && op == CSBU_OP_BRANCH_CARRY_CLEAR && !status_i[FLAG_C] |-> ##2 pc_o == $past(tgt, 2))
        else $error("carry clear branch wrong");
    a_signed_sel: assert property (
        go && (op == CSBU_OP_BRANCH_SIGNED_GE || op == CSBU_OP_BRANCH_SIGNED_LT) |=>
        busy_o == (($past(status_i[FLAG_N]) ^ $past(status_i[FLAG_V]))
        == ($past(instr_i.op) == CSBU_OP_BRANCH_SIGNED_LT)))
        else $error("signed branch choice wrong");
    a_flags_kept: assert property (pc_we_o |-> !status_we_o)
        else $error("flags written by branch");
endmodule

bind csbu_top csbu_top_assertions #(.PC_W(PC_W)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .instr_i(instr_i),
    .pc_i(pc_i), .status_i(status_i), .status_o(status_o), .status_we_o(status_we_o),
    .pc_o(pc_o), .pc_we_o(pc_we_o), .done_o(done_o), .busy_o(busy_o));

// File: tb/testbench.sv
// Purpose: Table driven test of the compare, skip and branch unit
// Assumes: Fetch model supplies the program counter
// Notes:   Expected program counter is a delta from the current one
`timescale 1ns/1ps
module testbench
    import csbu_pkg::*;
;
    typedef struct {csbu_instr_s i; logic [7:0] st; int cyc; logic [11:0] exp;} csbu_row_s;
    logic        clk = 1'b0, rst = 1'b1, start = 1'b0, sw;
    csbu_instr_s instr = '0;
    logic [7:0]  status = 8'h00, status_o;
    logic [11:0] pc, pc_new;
    logic        status_we, pc_we, done, busy;
    int          error_cnt = 0, n_compared = 0;
    csbu_row_s   rows[$];
    always #25 clk = ~clk;
    csbu_top #(.PC_W(12)) u_dut (.clk_sys_i(clk), .rst_i(rst), .start_i(start),
        .instr_i(instr), .pc_i(pc), .status_i(status), .status_o(status_o),
        .status_we_o(status_we), .pc_o(pc_new), .pc_we_o(pc_we), .done_o(done), .busy_o(busy));
    csbu_fetch_model #(.PC_W(12)) u_pc (.clk_i(clk), .rst_i(rst), .pc_we_i(pc_we),
        .pc_new_i(pc_new), .pc_o(pc));
    // ==========================================================
    // Helpers
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic csbu_instr_s mk(csbu_op_e op, logic [7:0] v, logic [7:0] k,
                                       logic [2:0] b, logic [6:0] off, logic two);
        mk = '{op, v, k, v, b, off, two};
    endfunction
    task automatic add(csbu_op_e op, logic [7:0] v, logic [7:0] k, logic [2:0] b,
                       logic [6:0] off, logic two, logic [7:0] st, int cyc, logic [11:0] exp);
        rows.push_back('{mk(op, v, k, b, off, two), st, cyc, exp});
    endtask
    task automatic run(input csbu_row_s r);
        int          n;
        logic [11:0] p;
        n = 0;
        sw = 1'b0;
        p = pc;
        instr = r.i;
        status = r.st;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 1;
        sw = status_we;
        while (done !== 1'b1) begin
            if (n == 5) begin
                error_cnt++;
                tally_and_finish();
            end
            @(posedge clk);
            #1 n++;
            sw |= status_we;
        end
        check(12'(n), 12'(r.cyc));
        check({11'h000, sw}, {11'h000, r.i.op == CSBU_OP_COMPARE_IMMEDIATE});
        if (r.i.op == CSBU_OP_COMPARE_IMMEDIATE) check({4'h0, status_o}, r.exp);
        else check(pc_new, p + r.exp);
        @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        add(CSBU_OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 3'h0, 7'h00, 1'b0, 8'hC0, 1, 12'h0D5);
        add(CSBU_OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 3'h0, 7'h00, 1'b0, 8'h00, 1, 12'h038);
        add(CSBU_OP_COMPARE_IMMEDIATE, 8'h5A, 8'h5A, 3'h0, 7'h00, 1'b0, 8'h00, 1, 12'h002);
        add(CSBU_OP_SKIP_REG_BIT_CLEAR, 8'hF7, 8'h00, 3'h3, 7'h00, 1'b0, 8'h00, 2, 12'h002);
        add(CSBU_OP_SKIP_REG_BIT_CLEAR, 8'h08, 8'h00, 3'h3, 7'h00, 1'b0, 8'h00, 1, 12'h001);
        add(CSBU_OP_SKIP_IO_BIT_SET, 8'h80, 8'h00, 3'h7, 7'h00, 1'b1, 8'h00, 3, 12'h003);
        add(CSBU_OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 3'h1, 7'h7F, 1'b0, 8'h02, 2, 12'h000);
        add(CSBU_OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 3'h5, 7'h40, 1'b0, 8'h00, 2, 12'hFC1);
        add(CSBU_OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 3'h5, 7'h40, 1'b0, 8'h20, 1, 12'h001);
        add(CSBU_OP_BRANCH_CARRY_CLEAR, 8'h00, 8'h00, 3'h0, 7'h3F, 1'b0, 8'h01, 1, 12'h001);
        add(CSBU_OP_BRANCH_CARRY_CLEAR, 8'h00, 8'h00, 3'h0, 7'h3F, 1'b0, 8'h00, 2, 12'h040);
        add(CSBU_OP_BRANCH_SIGNED_GE, 8'h00, 8'h00, 3'h0, 7'h02, 1'b0, 8'h0C, 2, 12'h003);
        add(CSBU_OP_BRANCH_SIGNED_GE, 8'h00, 8'h00, 3'h0, 7'h02, 1'b0, 8'h04, 1, 12'h001);
        add(CSBU_OP_BRANCH_SIGNED_LT, 8'h00, 8'h00, 3'h0, 7'h01, 1'b0, 8'h04, 2, 12'h002);
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        foreach (rows[k]) run(rows[k]);
        $display("table test done");
        // Start while busy is ignored
        instr = rows[5].i;
        start = 1'b1;
        @(posedge clk);
        #1 instr = rows[0].i;
        @(posedge clk);
        #1 start = 1'b0;
        sw = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1 sw |= status_we;
        end
        check({11'h000, sw}, 12'h000);
        $display("busy refusal test done");
        // Reset in mid operation
        instr = rows[5].i;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        rst = 1'b1;
        #1 check({busy, done, pc_we, status_we, status_o}, 12'h000);
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        run(rows[3]);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
